/* File: hw/sdc_regs.svh */
/*
  sdc_regs.svh: constants for the serial drive command controller (host side).
  assumes a 100 MHz clock; times are converted to cycle counts here.
*/
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

`define SDC_CLK_MHZ 100
// ==================================================
// gate spacing times
`define SDC_T_RD2WR_NS 300
`define SDC_T_WRGAP_NS 1000
`define SDC_T_WR2RD_NS 20000
`define SDC_T_HEAD_NS 20000
`define SDC_C_RD2WR ((`SDC_T_RD2WR_NS * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_C_WRGAP ((`SDC_T_WRGAP_NS * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_C_WR2RD ((`SDC_T_WR2RD_NS * `SDC_CLK_MHZ + 999) / 1000)
`define SDC_C_HEAD ((`SDC_T_HEAD_NS * `SDC_CLK_MHZ + 999) / 1000)
// ==================================================
// byte counts
`define SDC_DUMMY_BYTES 1
`define SDC_DISCARD_BYTES 4
`define SDC_PRESYNC_BYTES 10
// ==================================================
// command word fields
`define SDC_FN_MSB 15
`define SDC_FN_LSB 12
`define SDC_MOD_MSB 11
`define SDC_MOD_LSB 8
`define SDC_FN_SEEK 4'h0
`define SDC_FN_RECAL 4'h1
`define SDC_FN_STATUS 4'h2
`define SDC_FN_CONFIG 4'h3
`define SDC_FN_CONTROL 4'h5
`define SDC_FN_OFFSET 4'h7
`define SDC_FN_BPS 4'h9
`define SDC_WORD_BITS 17
`define SDC_BIT_CNT_W 5

`endif

/* File: hw/sdc_pkg.sv */
/*
  sdc_pkg.sv: types for the serial drive command controller.
  assumes sdc_regs.svh is on the include path.
*/
`default_nettype none
package sdc_pkg;
  typedef enum logic [4:0] {
    SDC_IDLE = 5'b00001,
    SDC_PRES = 5'b00010,
    SDC_REQ  = 5'b00100,
    SDC_REL  = 5'b01000,
    SDC_WAIT = 5'b10000
  } sdc_hs_e;
  typedef enum logic [2:0] {
    SDC_G_IDLE = 3'b001,
    SDC_G_RD   = 3'b010,
    SDC_G_WR   = 3'b100
  } sdc_gate_e;
endpackage
`default_nettype wire

/* File: hw/sdc_bit_if.sv */
/*
  sdc_bit_if.sv: carries one serial bit exchange between main and bit engine.
  assumes a single clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface sdc_bit_if;
  logic start;
  logic tx_bit;
  logic done;
  logic rx_bit;
  modport eng (input start, input tx_bit, output done, output rx_bit);
  modport ctl (output start, output tx_bit, input done, input rx_bit);
endinterface
`default_nettype wire

/* File: hw/sdc_bit_engine.sv */
/*
  sdc_bit_engine.sv: one request/acknowledge bit exchange on the serial lines.
  assumes ack and response data are synchronous to clock, active high inside.
*/
`timescale 1ns/1ns
`default_nettype none
module sdc_bit_engine
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  sdc_bit_if.eng bi,
  input wire logic ack,
  input wire logic resp_data,
  output logic req_ff,
  output logic cmd_ff
);
  // ==================================================
  // handshake state
  sdc_hs_e st_ff;
  sdc_hs_e nxt_st;
  logic done_ff;
  logic rx_ff;
  logic nxt_req;
  logic nxt_cmd;
  assign bi.done = done_ff;
  assign bi.rx_bit = rx_ff;
  always_comb
  begin
    nxt_st = st_ff;
    nxt_req = req_ff;
    nxt_cmd = cmd_ff;
    unique case (st_ff)
      SDC_IDLE:
      begin
        if (bi.start)
        begin
          nxt_cmd = bi.tx_bit;
          nxt_st = SDC_PRES;
        end
      end
      SDC_PRES:
      begin
        nxt_req = 1'b1;
        nxt_st = SDC_REQ;
      end
      SDC_REQ:
      begin
        if (ack)
        begin
          nxt_req = 1'b0;
          nxt_st = SDC_REL;
        end
      end
      SDC_REL:
      begin
        if (!ack)
        begin
          nxt_st = SDC_IDLE;
        end
      end
      default:
      begin
        nxt_st = SDC_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= SDC_IDLE;
      req_ff <= 1'b0;
      cmd_ff <= 1'b0;
      done_ff <= 1'b0;
      rx_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      req_ff <= nxt_req;
      cmd_ff <= (nxt_st == SDC_IDLE) ? 1'b0 : nxt_cmd;
      done_ff <= (st_ff == SDC_REL) && !ack;
      if (st_ff == SDC_REQ && ack)
      begin
        rx_ff <= resp_data;
      end
    end
  end
  // ==================================================
  // checks
  property p_req_drop;
    @(posedge clock) disable iff (!rst_b)
    (st_ff == SDC_REQ && ack) |=> !req_ff;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("req not dropped after ack");
  property p_data_stable;
    @(posedge clock) disable iff (!rst_b)
    req_ff && $past(req_ff) |-> $stable(cmd_ff);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved under req");
endmodule // sdc_bit_engine
`default_nettype wire

/* File: hw/sdc_ctrl.sv */
/*
  sdc_ctrl.sv: host-side controller for a serial-mode disk drive: head select,
  read/write gate spacing and serial command/response transfer.
  assumes all drive pins are synchronous to clock; pins are active high here,
  the pad ring inverts the active-low cable lines.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sdc_regs.svh"
// Function
// - hold valid head while gates active
// - write fault invalidates sector, rewrite
// - read-to-write gap at least 300 ns
// - write gate off one microsecond between
// - write-to-read gap 20 microseconds
// - one dummy byte before write off
// - head settle 20 us, skip 4 bytes
// - read gate 10 bytes before sync (SDC_PRESYNC_BYTES is not used by this logic)
// - 16-bit word MSB first, odd parity
// - function, modifier or parameter fields
// - no bits during done; idle high
module sdc_ctrl
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic cmd_expect_resp,
  output logic cmd_ready_ff,
  output logic resp_valid_ff,
  output logic [15:0] resp_word_ff,
  output logic resp_parity_err_ff,
  input wire logic [3:0] head_req,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic byte_tick,
  output logic rd_ok_ff,
  output logic wr_ok_ff,
  output logic wr_fault_seen_ff,
  output logic [3:0] head_sel_ff,
  output logic rd_gate_ff,
  output logic wr_gate_ff,
  output logic xfer_req_ff,
  output logic cmd_data_ff,
  input wire logic xfer_ack,
  input wire logic resp_data,
  input wire logic cmd_done,
  input wire logic write_fault
);
  // ==================================================
  // serial word transfer
  sdc_bit_if bi();
  logic req_w;
  logic cmd_w;
  sdc_bit_engine u_eng (
    .clock(clock),
    .rst_b(rst_b),
    .bi(bi),
    .ack(xfer_ack),
    .resp_data(resp_data),
    .req_ff(req_w),
    .cmd_ff(cmd_w)
  );
  function automatic logic odd_par(input logic [15:0] w);
    odd_par = ~(^w);
  endfunction
  logic [16:0] tx_ff;
  logic [16:0] rx_ff;
  logic [`SDC_BIT_CNT_W-1:0] cnt_ff;
  logic busy_ff;
  logic rx_mode_ff;
  logic bit_go_ff;
  logic exp_ff;
  logic last_bit;
  logic start_ok;
  assign last_bit = (cnt_ff == 5'(`SDC_WORD_BITS - 1));
  // wait for done low before sending
  assign start_ok = cmd_valid && cmd_ready_ff && !cmd_done;
  assign bi.start = bit_go_ff;
  assign bi.tx_bit = rx_mode_ff ? 1'b0 : tx_ff[16];
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_ff <= 17'h0_0000;
      rx_ff <= 17'h0_0000;
      cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      rx_mode_ff <= 1'b0;
      bit_go_ff <= 1'b0;
      exp_ff <= 1'b0;
      cmd_ready_ff <= 1'b1;
      resp_valid_ff <= 1'b0;
      resp_word_ff <= 16'h0000;
      resp_parity_err_ff <= 1'b0;
    end
    else
    begin
      bit_go_ff <= 1'b0;
      resp_valid_ff <= 1'b0;
      if (start_ok)
      begin
        tx_ff <= {cmd_word, odd_par(cmd_word)};
        exp_ff <= cmd_expect_resp;
        cnt_ff <= 5'h00;
        busy_ff <= 1'b1;
        rx_mode_ff <= 1'b0;
        bit_go_ff <= 1'b1;
        cmd_ready_ff <= 1'b0;
      end
      else if (busy_ff && bi.done)
      begin
        tx_ff <= {tx_ff[15:0], 1'b0};
        if (rx_mode_ff)
        begin
          rx_ff <= {rx_ff[15:0], bi.rx_bit};
        end
        if (!last_bit)
        begin
          cnt_ff <= cnt_ff + 5'h01;
          bit_go_ff <= 1'b1;
        end
        else if (!rx_mode_ff && exp_ff)
        begin
          cnt_ff <= 5'h00;
          rx_mode_ff <= 1'b1;
          bit_go_ff <= 1'b1;
        end
        else
        begin
          busy_ff <= 1'b0;
        end
      end
      else if (!busy_ff && !cmd_ready_ff && !cmd_done)
      begin
        cmd_ready_ff <= 1'b1;
        if (rx_mode_ff)
        begin
          resp_valid_ff <= 1'b1;
          resp_word_ff <= rx_ff[16:1];
          resp_parity_err_ff <= (odd_par(rx_ff[16:1]) != rx_ff[0]);
        end
      end
    end
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xfer_req_ff <= 1'b0;
      cmd_data_ff <= 1'b0;
    end
    else
    begin
      xfer_req_ff <= req_w;
      cmd_data_ff <= cmd_w;
    end
  end
  // ==================================================
  // gate sequencing
  sdc_gate_e g_ff;
  sdc_gate_e nxt_g;
  logic [11:0] since_rd_ff;
  logic [11:0] since_wr_ff;
  logic [11:0] since_hd_ff;
  logic [3:0] bytes_ff;
  logic rd_allow;
  logic wr_allow;
  logic head_chg;
  assign head_chg = (head_req != head_sel_ff) && (g_ff == SDC_G_IDLE);
  assign rd_allow = (since_wr_ff >= 12'(`SDC_C_WR2RD)) && (since_hd_ff >= 12'(`SDC_C_HEAD));
  assign wr_allow = (since_rd_ff >= 12'(`SDC_C_RD2WR)) && (since_wr_ff >= 12'(`SDC_C_WRGAP));
  always_comb
  begin
    nxt_g = g_ff;
    unique case (g_ff)
      SDC_G_IDLE:
      begin
        if (wr_req && wr_allow && !head_chg)
        begin
          nxt_g = SDC_G_WR;
        end
        else if (rd_req && rd_allow && !head_chg)
        begin
          nxt_g = SDC_G_RD;
        end
      end
      SDC_G_RD:
      begin
        if (!rd_req)
        begin
          nxt_g = SDC_G_IDLE;
        end
      end
      SDC_G_WR:
      begin
        // one dummy byte after data ends
        if (!wr_req && bytes_ff >= 4'(`SDC_DUMMY_BYTES))
        begin
          nxt_g = SDC_G_IDLE;
        end
      end
      default:
      begin
        nxt_g = SDC_G_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      g_ff <= SDC_G_IDLE;
      since_rd_ff <= 12'hfff;
      since_wr_ff <= 12'hfff;
      since_hd_ff <= 12'hfff;
      bytes_ff <= 4'h0;
      head_sel_ff <= 4'h0;
      rd_gate_ff <= 1'b0;
      wr_gate_ff <= 1'b0;
      rd_ok_ff <= 1'b0;
      wr_ok_ff <= 1'b0;
    end
    else
    begin
      g_ff <= nxt_g;
      // head only changes with both gates off
      if (head_chg)
      begin
        head_sel_ff <= head_req;
      end
      since_hd_ff <= head_chg ? 12'h000 : since_hd_ff + {11'h000, since_hd_ff != 12'hfff};
      since_rd_ff <= rd_gate_ff ? 12'h000 : since_rd_ff + {11'h000, since_rd_ff != 12'hfff};
      since_wr_ff <= wr_gate_ff ? 12'h000 : since_wr_ff + {11'h000, since_wr_ff != 12'hfff};
      if (nxt_g != g_ff || (g_ff == SDC_G_WR && wr_req))
      begin
        bytes_ff <= 4'h0;
      end
      else if (byte_tick && bytes_ff != 4'hf)
      begin
        bytes_ff <= bytes_ff + 4'h1;
      end
      // read gate opens on rd_req once rd_allow holds, no head change is pending and no wr_req with wr_allow wins first
      rd_gate_ff <= (nxt_g == SDC_G_RD);
      wr_gate_ff <= (nxt_g == SDC_G_WR);
      wr_ok_ff <= (nxt_g == SDC_G_WR) && wr_req;
      // discard first bytes after read gate
      rd_ok_ff <= (g_ff == SDC_G_RD) && (nxt_g == SDC_G_RD) &&
                  (bytes_ff >= 4'(`SDC_DISCARD_BYTES));
    end
  end
  // fault under write gate: sector must be rewritten
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_fault_seen_ff <= 1'b0;
    end
    else if (wr_gate_ff && write_fault)
    begin
      wr_fault_seen_ff <= 1'b1;
    end
    else if (wr_req && !wr_gate_ff && !write_fault)
    begin
      wr_fault_seen_ff <= 1'b0;
    end
  end
  // ==================================================
  // checks
  property p_rd2wr;
    @(posedge clock) disable iff (!rst_b)
    $rose(wr_gate_ff) |-> since_rd_ff >= 12'(`SDC_C_RD2WR);
  endproperty
  a_rd2wr: assert property (p_rd2wr) else $error("write gate too soon after read");
  property p_wrgap;
    @(posedge clock) disable iff (!rst_b)
    $rose(wr_gate_ff) |-> since_wr_ff >= 12'(`SDC_C_WRGAP);
  endproperty
  a_wrgap: assert property (p_wrgap) else $error("write gate gap too short");
  property p_wr2rd;
    @(posedge clock) disable iff (!rst_b)
    $rose(rd_gate_ff) |-> since_wr_ff >= 12'(`SDC_C_WR2RD);
  endproperty
  a_wr2rd: assert property (p_wr2rd) else $error("read gate too soon after write");
  property p_head;
    @(posedge clock) disable iff (!rst_b)
    (rd_gate_ff || wr_gate_ff) |=> $stable(head_sel_ff);
  endproperty
  a_head: assert property (p_head) else $error("head moved under gate");
  property p_settle;
    @(posedge clock) disable iff (!rst_b)
    $rose(rd_gate_ff) |-> since_hd_ff >= 12'(`SDC_C_HEAD);
  endproperty
  a_settle: assert property (p_settle) else $error("read before head settle");
  property p_noread;
    @(posedge clock) disable iff (!rst_b)
    $rose(rd_gate_ff) |-> !rd_ok_ff ##1 !rd_ok_ff;
  endproperty
  a_noread: assert property (p_noread) else $error("read data used too early");
  property p_done_quiet;
    @(posedge clock) disable iff (!rst_b)
    $rose(xfer_req_ff) |-> busy_ff && (rx_mode_ff || !cmd_done);
  endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("request outside transfer");
  property p_idle_line;
    @(posedge clock) disable iff (!rst_b)
    !busy_ff ##1 !busy_ff |-> !cmd_data_ff;
  endproperty
  a_idle_line: assert property (p_idle_line) else $error("command line active when idle");
  property p_parity;
    @(posedge clock) disable iff (!rst_b)
    start_ok |=> ^tx_ff;
  endproperty
  a_parity: assert property (p_parity) else $error("parity not odd");
  property p_dummy;
    @(posedge clock) disable iff (!rst_b)
    $fell(wr_gate_ff) |-> $past(bytes_ff) >= 4'(`SDC_DUMMY_BYTES);
  endproperty
  a_dummy: assert property (p_dummy) else $error("no dummy byte");
  c_cmd: cover property (@(posedge clock) disable iff (!rst_b) start_ok);
  c_resp: cover property (@(posedge clock) disable iff (!rst_b) resp_valid_ff);
  c_wr: cover property (@(posedge clock) disable iff (!rst_b) $fell(wr_gate_ff));
  c_rd: cover property (@(posedge clock) disable iff (!rst_b) rd_ok_ff);
endmodule // sdc_ctrl
`default_nettype wire

/* File: tb/sdc_drive_model.sv */
/*
  sdc_drive_model.sv: behavioural serial-mode drive facing the controller.
  assumes active-high pins on one clock; the bench steers delays and faults.
*/
`timescale 1ns/1ns
`default_nettype none
module sdc_drive_model
  import sdc_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID = 16'h5a3c  // arbitrary value
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic xfer_req,
  input wire logic cmd_data,
  input wire logic wr_gate,
  input wire logic slow,
  input wire logic bad_par,
  input wire logic fault_inj,
  output logic xfer_ack,
  output logic resp_data,
  output logic cmd_done,
  output logic write_fault,
  output logic [15:0] got_word,
  output logic got_par_ok,
  output logic bad_order
);
  logic [16:0] sr_ff;
  logic [16:0] tx_ff;
  logic [5:0] n_ff;
  logic [3:0] dly_ff;
  logic [4:0] busy_ff;
  logic want_ff;
  logic wf_lat_ff;
  logic [15:0] rsp;
  wire [3:0] fn = sr_ff[16:13];
  wire [3:0] md = sr_ff[12:9];
  // ====
  // response word
  // modifier picks item
  always_comb
  begin
    rsp = 16'h0000;
    if (fn == 4'h2 && md == 4'h1)
      rsp = {12'h000, wf_lat_ff, 3'h0};
    else if (fn == 4'h2)
      rsp = {14'h0000, wf_lat_ff, 1'b0};
    else if (md == 4'h1)
      rsp = 16'h0337;
    else if (md == 4'h4)
      rsp = 16'h51d0;
    else if (md == 4'h7)
      rsp = 16'h0c1d;
    else if (md == 4'h8)
      rsp = 16'h000b;
    else if (md == 4'he)
      rsp = VENDOR_ID;
  end
  assign write_fault = fault_inj & wr_gate;
  // released line shows the inverse, not the last bit
  assign resp_data = (want_ff && cmd_done) ? tx_ff[16] : ~tx_ff[16];
  // ====
  // handshake and execution
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xfer_ack <= 1'b0;
      cmd_done <= 1'b0;
      sr_ff <= 17'h0_0000;
      tx_ff <= 17'h0_0000;
      n_ff <= 6'h00;
      dly_ff <= 4'h0;
      busy_ff <= 5'h00;
      want_ff <= 1'b0;
      wf_lat_ff <= 1'b0;
      got_word <= 16'h0000;
      got_par_ok <= 1'b0;
      bad_order <= 1'b0;
    end
    else
    begin
      if (write_fault)
        wf_lat_ff <= 1'b1;
      if (dly_ff != 4'h0)
        dly_ff <= dly_ff - 4'h1;
      else if (xfer_req && !xfer_ack)
      begin
        xfer_ack <= 1'b1;
        if (cmd_done && !want_ff)
          bad_order <= 1'b1;
        if (!cmd_done)
          sr_ff <= {sr_ff[15:0], cmd_data};
      end
      else if (!xfer_req && xfer_ack)
      begin
        xfer_ack <= 1'b0;
        dly_ff <= slow ? 4'h9 : 4'h1;
        n_ff <= n_ff + 6'h01;
        if (cmd_done)
          tx_ff <= {tx_ff[15:0], tx_ff[16]};
      end
      if (!cmd_done && n_ff == 6'h11)
      begin
        cmd_done <= 1'b1;
        n_ff <= 6'h00;
        got_word <= sr_ff[16:1];
        got_par_ok <= ^sr_ff;
        busy_ff <= 5'h14;
        want_ff <= (fn == 4'h2 || fn == 4'h3);
        tx_ff <= {rsp, ~^rsp ^ bad_par};
        if (fn == 4'h5 && md == 4'h0 && !write_fault)
          wf_lat_ff <= 1'b0;
      end
      if (cmd_done && want_ff && n_ff == 6'h11)
      begin
        cmd_done <= 1'b0;
        want_ff <= 1'b0;
        n_ff <= 6'h00;
      end
      if (cmd_done && !want_ff)
      begin
        busy_ff <= busy_ff - 5'h01;
        if (busy_ff == 5'h00)
          cmd_done <= 1'b0;
      end
    end
  end
endmodule // sdc_drive_model
`default_nettype wire

/* File: tb/tb_top.sv */
/*
  tb_top.sv: self-checking bench, sdc_ctrl against a behavioural drive.
  assumes sdc_regs.svh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sdc_regs.svh"
module tb_top;
  localparam logic [15:0] VID = 16'h5a3c;  // arbitrary value
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  logic cmd_expect_resp = 1'b0;
  logic [3:0] head_req = 4'h0;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic byte_tick = 1'b0;
  logic slow = 1'b0;
  logic bad_par = 1'b0;
  logic fault_inj = 1'b0;
  logic cmd_ready_ff, resp_valid_ff, resp_parity_err_ff, rd_ok_ff, wr_ok_ff;
  logic wr_fault_seen_ff, rd_gate_ff, wr_gate_ff, xfer_req_ff, cmd_data_ff;
  logic xfer_ack, resp_data, cmd_done, write_fault, m_par, m_bad;
  logic [15:0] resp_word_ff, m_word;
  logic [3:0] head_sel_ff, hs_q;
  logic [3:0] bt_cnt = 4'h0;
  logic wg_q, rg_q, ok_q, rv_seen, pe_seen;
  int bad_count = 0;
  int cmp_count = 0;
  int rd_off = 100000;
  int wr_off = 100000;
  int hd_age = 100000;
  int wtk = 0;
  int rtk = 0;
  sdc_ctrl DUT (.clock, .rst_b, .cmd_valid, .cmd_word, .cmd_expect_resp, .cmd_ready_ff,
    .resp_valid_ff, .resp_word_ff, .resp_parity_err_ff, .head_req, .rd_req, .wr_req,
    .byte_tick, .rd_ok_ff, .wr_ok_ff, .wr_fault_seen_ff, .head_sel_ff, .rd_gate_ff,
    .wr_gate_ff, .xfer_req_ff, .cmd_data_ff, .xfer_ack, .resp_data, .cmd_done, .write_fault);
  sdc_drive_model #(.VENDOR_ID(VID)) u_drive (.clock, .rst_b, .xfer_req(xfer_req_ff),
    .cmd_data(cmd_data_ff), .wr_gate(wr_gate_ff), .slow, .bad_par, .fault_inj, .xfer_ack,
    .resp_data, .cmd_done, .write_fault, .got_word(m_word), .got_par_ok(m_par),
    .bad_order(m_bad));
  // ====
  // shared tasks
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return wr_gate_ff;
      1: return rd_gate_ff;
      2: return rd_ok_ff;
      default: return cmd_ready_ff;
    endcase
  endfunction
  // waits on settled values at falling edges, bounded
  task automatic wait_v(input int w, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && sel(w) !== v; i++)
    begin
      @(negedge clock);
      rv_seen |= (resp_valid_ff === 1'b1);
      pe_seen |= (resp_valid_ff === 1'b1 && resp_parity_err_ff === 1'b1);
    end
    if (i == lim)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic send(input logic [15:0] w, input logic er);
    wait_v(3, 1'b1, 30000);
    cmd_word = w;
    cmd_expect_resp = er;
    cmd_valid = 1'b1;
    rv_seen = 1'b0;
    pe_seen = 1'b0;
    wait_v(3, 1'b0, 50);
    cmd_valid = 1'b0;
    wait_v(3, 1'b1, 30000);
  endtask
  // ====
  // scenarios
  task automatic t_cmds();
    logic [15:0] tb [6] = '{16'h0123, 16'h1000, 16'h4000, 16'h5000, 16'h7300, 16'h9200};
    foreach (tb[k])
    begin
      slow = k[0];
      send(tb[k], 1'b0);
      chk(m_word, tb[k]);
      chk(m_par, 1'b1);
      chk(m_bad, 1'b0);
      chk(cmd_data_ff, 1'b0);
    end
    $display("test commands ended");
  endtask
  task automatic t_resp();
    logic [15:0] c [5] = '{16'h3100, 16'h3400, 16'h3700, 16'h3e00, 16'h2000};
    logic [15:0] e [5] = '{16'h0337, 16'h51d0, 16'h0c1d, VID, 16'h0000};
    foreach (c[k])
    begin
      slow = k[0];
      bad_par = (k == 4);
      send(c[k], 1'b1);
      chk(rv_seen, 1'b1);
      chk(resp_word_ff, e[k]);
      chk(pe_seen, k == 4);
    end
    bad_par = 1'b0;
    $display("test responses ended");
  endtask
  task automatic t_gates();
    wr_req = 1'b1;
    wait_v(0, 1'b1, 3000);
    repeat (40) @(negedge clock);
    wr_req = 1'b0;
    wait_v(0, 1'b0, 100);
    wr_req = 1'b1;
    wait_v(0, 1'b1, 3000);
    wr_req = 1'b0;
    wait_v(0, 1'b0, 100);
    rd_req = 1'b1;
    wait_v(1, 1'b1, 3000);
    head_req = 4'h3;
    wait_v(2, 1'b1, 3000);
    chk(head_sel_ff, 4'h0);
    rd_req = 1'b0;
    wr_req = 1'b1;
    wait_v(0, 1'b1, 3000);
    wr_req = 1'b0;
    wait_v(0, 1'b0, 100);
    rd_req = 1'b1;
    wait_v(2, 1'b1, 5000);
    chk(head_sel_ff, 4'h3);
    rd_req = 1'b0;
    wait_v(1, 1'b0, 100);
    $display("test gates ended");
  endtask
  task automatic t_fault();
    fault_inj = 1'b1;
    wr_req = 1'b1;
    wait_v(0, 1'b1, 3000);
    repeat (5) @(negedge clock);
    chk(wr_fault_seen_ff, 1'b1);
    fault_inj = 1'b0;
    wr_req = 1'b0;
    wait_v(0, 1'b0, 100);
    repeat (150) @(negedge clock);
    wr_req = 1'b1;
    wait_v(0, 1'b1, 3000);
    repeat (3) @(negedge clock);
    chk(wr_fault_seen_ff, 1'b0);
    chk(wr_ok_ff, 1'b1);
    wr_req = 1'b0;
    wait_v(0, 1'b0, 100);
    send(16'h2000, 1'b1);
    chk(resp_word_ff, 16'h0002);
    send(16'h2100, 1'b1);
    chk(resp_word_ff, 16'h0008);
    send(16'h5000, 1'b0);
    send(16'h2000, 1'b1);
    chk(resp_word_ff, 16'h0000);
    $display("test write fault ended");
  endtask
  // ====
  // clock, byte time, gate spacing monitor
  initial
  begin
    forever #5 clock = ~clock;
  end
  always @(negedge clock)
  begin
    bt_cnt <= bt_cnt + 4'h1;
    byte_tick <= (bt_cnt == 4'hf);
  end
  always @(negedge clock)
  begin
    if (wr_gate_ff === 1'b1 && wg_q === 1'b0)
    begin
      chk(rd_off >= `SDC_C_RD2WR, 1'b1);
      chk(wr_off >= `SDC_C_WRGAP, 1'b1);
    end
    if (rd_gate_ff === 1'b1 && rg_q === 1'b0)
      chk(wr_off >= `SDC_C_WR2RD, 1'b1);
    if (wr_gate_ff === 1'b0 && wg_q === 1'b1)
      chk(wtk >= `SDC_DUMMY_BYTES, 1'b1);
    if (rd_ok_ff === 1'b1 && ok_q === 1'b0)
    begin
      chk(hd_age >= `SDC_C_HEAD, 1'b1);
      chk(rtk >= `SDC_DISCARD_BYTES, 1'b1);
    end
    if ((wg_q | rg_q) === 1'b1 && head_sel_ff !== hs_q)
      chk(head_sel_ff, hs_q);
    rd_off = (rd_gate_ff === 1'b1) ? 0 : rd_off + 1;
    wr_off = (wr_gate_ff === 1'b1) ? 0 : wr_off + 1;
    hd_age = (head_sel_ff !== hs_q) ? 0 : hd_age + 1;
    wtk = (wg_q === 1'b1 && wr_gate_ff === 1'b1) ? wtk + (wr_ok_ff ? 0 : byte_tick) : 0;
    rtk = (rg_q === 1'b1) ? rtk + byte_tick : 0;
    wg_q = wr_gate_ff;
    rg_q = rd_gate_ff;
    ok_q = rd_ok_ff;
    hs_q = head_sel_ff;
  end
  initial
  begin
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    t_cmds();
    t_resp();
    t_gates();
    t_fault();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
